// ==== hdl/nvac_access_control.sv ====
`timescale 1ns/1ps
// Behaviour
// (R1) Software runs the unlock sequence before any program flash write or erase.
// (R2) Data EEPROM reached only indirectly through address and 8-bit data registers.
// (R3) Single-byte reads and single-byte writes of data EEPROM are supported.
// (R4) A byte write erases the location first, then programs the new value.
// (R5) Internal programming timer sets write length; expiry signals completion.
// (R6) Memory select 0 targets data EEPROM, 1 targets program memory.
// (R7) Configuration select 1 targets configuration space, else memory select decides.
// (R8) Writes start only with write enable set; write enable clears at power-up.
// (R9) Write error sets when write enable is set, clears on write completion.
// (R10) Write error reading 1 shows a write cut short or attempted wrongly.
// (R11) Start write is set-only by software; hardware clears it at finish.
// (R12) Start read and start write launch operations; hardware clears each at completion.
// (R13) Start read cannot be set while memory select is 1.
// (R14) Write complete flag, bit 4 of flag register two, sets on finish.
// (R15) Unlock register stores nothing and reads as all zeros.
// (R16) Unimplemented bits, including control bit 5, read as zero.
// (R17) Row erase makes next start write erase the pointed row, then clears.
// (R18) Both unlock bytes written back to back right before start write.
// (R19) A read leaves the addressed byte in the data register as start read clears.
module nvac_access_control #(
  parameter int unsigned EE_ADDR_WIDTH = 8,
  parameter int unsigned ERASE_CYCLES  = nvac_pkg::EE_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES   = nvac_pkg::EE_PROG_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      warm_reset,
  input  wire nvac_pkg::nvac_sfr_req_t   sfr_req,
  output logic [7:0]                     sfr_rdata,
  input  wire nvac_pkg::nvac_table_req_t table_req,
  output logic                           core_stall,
  output logic                           flash_req,
  output nvac_pkg::nvac_flash_cmd_t      flash_cmd,
  input  wire logic                      flash_done,
  input  wire logic [7:0]                flash_rdata,
  output logic                           write_complete_flag
);

  typedef enum {ST_IDLE, ST_ERASE, ST_PROGRAM, ST_FLASH} nvac_state_t;
  typedef enum {UL_IDLE, UL_FIRST, UL_ARMED} nvac_unlock_t;

  localparam int unsigned        TIMER_W    = nvac_pkg::TIMER_WIDTH;
  localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(ERASE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] PROG_LOAD  = TIMER_W'(PROG_CYCLES - 1);

  nvac_state_t                  state_reg;
  nvac_unlock_t                 unlock_reg;
  logic [TIMER_W-1:0]           timer_reg;
  logic                         memory_select_reg;
  logic                         configuration_select_reg;
  logic                         row_erase_reg;
  logic                         write_enable_reg;
  logic                         write_error_flag_reg;
  logic                         start_write_reg;
  logic                         start_read_reg;
  logic                         write_complete_flag_reg;
  logic [7:0]                   nv_data_register_reg;
  logic [EE_ADDR_WIDTH-1:0]     nv_address_register_reg;
  logic [21:0]                  table_pointer_reg;
  logic [7:0]                   table_latch_reg;
  logic [7:0]                   ee_wdata_reg;
  logic [EE_ADDR_WIDTH-1:0]     ee_waddr_reg;
  logic                         post_inc_reg;
  logic                         flash_req_reg;
  nvac_pkg::nvac_flash_cmd_t    flash_cmd_reg;
  logic [7:0]                   sfr_rdata_reg;
  logic [7:0]                   ee_mem [2**EE_ADDR_WIDTH];

  logic ctl_wr;
  logic wr_accept;
  logic rd_accept;
  logic table_take;
  logic write_finish;
  logic target_eeprom;
  logic [7:0] control_view;

  function automatic logic sfr_write(input nvac_pkg::nvac_sfr_req_t req,
                                     input logic [7:0]             addr);
    return req.wr && (req.addr == addr);
  endfunction

  assign ctl_wr        = sfr_write(sfr_req, nvac_pkg::SFR_CONTROL);
  assign target_eeprom = !configuration_select_reg && !memory_select_reg; // R6 R7
  // Start write only with enable held and the unlock pair just written
  assign wr_accept = ctl_wr && sfr_req.wdata[nvac_pkg::CTL_START_WRITE]
                     && write_enable_reg && (unlock_reg == UL_ARMED) // R8 R1 R18
                     && !start_write_reg && (state_reg == ST_IDLE);
  assign rd_accept = ctl_wr && sfr_req.wdata[nvac_pkg::CTL_START_READ]
                     && !sfr_req.wdata[nvac_pkg::CTL_MEMORY_SELECT] // R13
                     && !start_write_reg && (state_reg == ST_IDLE);
  assign table_take = (table_req.read || table_req.write)
                      && (state_reg == ST_IDLE) && !start_write_reg;
  assign write_finish = ((state_reg == ST_PROGRAM) && (timer_reg == '0)) // R5
                        || ((state_reg == ST_FLASH) && flash_done
                            && (flash_cmd_reg.op == nvac_pkg::NVAC_FL_ROW_PROGRAM
                                || flash_cmd_reg.op == nvac_pkg::NVAC_FL_ROW_ERASE));
  // Core waits for flash work; a data EEPROM write runs in the background
  assign core_stall = (state_reg == ST_FLASH)
                      || ((table_req.read || table_req.write) && !table_take);

  assign control_view = {memory_select_reg, configuration_select_reg, 1'b0, // R16
                         row_erase_reg, write_error_flag_reg, write_enable_reg,
                         start_write_reg, start_read_reg};

  assign sfr_rdata           = sfr_rdata_reg;
  assign flash_req           = flash_req_reg;
  assign flash_cmd           = flash_cmd_reg;
  assign write_complete_flag = write_complete_flag_reg;

  // Any other register write between the keys or before start write disarms
  always_ff @(posedge clock) begin
    if (reset || warm_reset) begin
      unlock_reg <= UL_IDLE;
    end else if (sfr_req.wr) begin
      if (sfr_write(sfr_req, nvac_pkg::SFR_UNLOCK)) begin // R18
        if (sfr_req.wdata == nvac_pkg::UNLOCK_KEY_FIRST) begin
          unlock_reg <= UL_FIRST;
        end else if (unlock_reg == UL_FIRST
                     && sfr_req.wdata == nvac_pkg::UNLOCK_KEY_SECOND) begin
          unlock_reg <= UL_ARMED;
        end else begin
          unlock_reg <= UL_IDLE;
        end
      end else begin
        unlock_reg <= UL_IDLE;
      end
    end
  end

  // Select, enable and row-erase fields; power-up and warm reset both clear
  always_ff @(posedge clock) begin
    if (reset || warm_reset) begin
      memory_select_reg        <= 1'b0;
      configuration_select_reg <= 1'b0;
      row_erase_reg            <= 1'b0;
      write_enable_reg         <= 1'b0; // R8
    end else begin
      if (write_finish && flash_cmd_reg.op == nvac_pkg::NVAC_FL_ROW_ERASE
          && state_reg == ST_FLASH) begin
        row_erase_reg <= 1'b0; // R17
      end
      if (ctl_wr) begin
        memory_select_reg        <= sfr_req.wdata[nvac_pkg::CTL_MEMORY_SELECT]; // R6
        configuration_select_reg <= sfr_req.wdata[nvac_pkg::CTL_CONFIG_SELECT]; // R7
        row_erase_reg            <= sfr_req.wdata[nvac_pkg::CTL_ROW_ERASE];
        write_enable_reg         <= sfr_req.wdata[nvac_pkg::CTL_WRITE_ENABLE];
      end
    end
  end

  // Survives warm reset so an interrupted write stays visible afterwards
  always_ff @(posedge clock) begin
    if (reset) begin
      write_error_flag_reg <= 1'b0;
    end else if (ctl_wr && sfr_req.wdata[nvac_pkg::CTL_WRITE_ENABLE]) begin
      write_error_flag_reg <= 1'b1; // R9 R10
    end else if (write_finish) begin
      write_error_flag_reg <= 1'b0; // R9
    end else if (ctl_wr) begin
      write_error_flag_reg <= sfr_req.wdata[nvac_pkg::CTL_WRITE_ERROR];
    end
  end

  // Writing 0 to start write never clears it
  always_ff @(posedge clock) begin
    if (reset || warm_reset) begin
      start_write_reg <= 1'b0;
    end else if (wr_accept) begin
      start_write_reg <= 1'b1; // R11 R12
    end else if (write_finish) begin
      start_write_reg <= 1'b0; // R11
    end
  end

  always_ff @(posedge clock) begin
    if (reset || warm_reset) begin
      start_read_reg <= 1'b0;
    end else begin
      start_read_reg <= rd_accept; // R12 R3
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      write_complete_flag_reg <= 1'b0;
    end else if (write_finish) begin
      write_complete_flag_reg <= 1'b1; // R14
    end else if (sfr_write(sfr_req, nvac_pkg::SFR_PERIPH_TWO)) begin
      write_complete_flag_reg <= sfr_req.wdata[nvac_pkg::PERIPHERAL_FLAG_REG_TWO_WRITE_DONE];
    end
  end

  // Data register also takes the array byte when a read is in flight
  always_ff @(posedge clock) begin
    if (reset) begin
      nv_data_register_reg    <= nvac_pkg::DATA_RESET;
      nv_address_register_reg <= '0;
    end else begin
      if (start_read_reg) begin
        nv_data_register_reg <= ee_mem[nv_address_register_reg]; // R19 R2
      end else if (sfr_write(sfr_req, nvac_pkg::SFR_DATA)) begin
        nv_data_register_reg <= sfr_req.wdata;
      end
      if (sfr_write(sfr_req, nvac_pkg::SFR_ADDRESS)) begin
        nv_address_register_reg <= sfr_req.wdata[EE_ADDR_WIDTH-1:0]; // R2
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      table_pointer_reg <= nvac_pkg::TABLE_POINTER_RESET;
      table_latch_reg   <= nvac_pkg::DATA_RESET;
    end else begin
      if (state_reg == ST_FLASH && flash_done) begin
        if (flash_cmd_reg.op == nvac_pkg::NVAC_FL_TABLE_READ) begin
          table_latch_reg <= flash_rdata;
        end
        if (post_inc_reg) begin
          table_pointer_reg <= table_pointer_reg + 22'h000001;
        end
      end
      if (sfr_write(sfr_req, nvac_pkg::SFR_TABLE_POINTER_LOW)) begin
        table_pointer_reg[7:0] <= sfr_req.wdata;
      end
      if (sfr_write(sfr_req, nvac_pkg::SFR_TABLE_POINTER_HIGH)) begin
        table_pointer_reg[15:8] <= sfr_req.wdata;
      end
      if (sfr_write(sfr_req, nvac_pkg::SFR_TABLE_POINTER_UP)) begin
        table_pointer_reg[21:16] <= sfr_req.wdata[5:0];
      end
      if (sfr_write(sfr_req, nvac_pkg::SFR_TABLE_LATCH)) begin
        table_latch_reg <= sfr_req.wdata;
      end
    end
  end

  // Array has no reset: its contents are nonvolatile
  always_ff @(posedge clock) begin
    if (state_reg == ST_PROGRAM && timer_reg == '0) begin
      ee_mem[ee_waddr_reg] <= ee_wdata_reg; // R4 R3
    end
  end

  always_ff @(posedge clock) begin
    if (reset || warm_reset) begin
      state_reg     <= ST_IDLE;
      timer_reg     <= '0;
      flash_req_reg <= 1'b0;
      post_inc_reg  <= 1'b0;
      ee_waddr_reg  <= '0;
      ee_wdata_reg  <= nvac_pkg::DATA_RESET;
      flash_cmd_reg <= '0;
    end else begin
      flash_req_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_write_reg) begin
            post_inc_reg <= 1'b0;
            if (target_eeprom) begin
              ee_waddr_reg <= nv_address_register_reg;
              ee_wdata_reg <= nv_data_register_reg;
              timer_reg    <= ERASE_LOAD;
              state_reg    <= ST_ERASE; // R4
            end else begin
              flash_cmd_reg.op <= row_erase_reg ? nvac_pkg::NVAC_FL_ROW_ERASE // R17
                                                : nvac_pkg::NVAC_FL_ROW_PROGRAM;
              flash_cmd_reg.config_space <= configuration_select_reg; // R7
              flash_cmd_reg.addr         <= table_pointer_reg;
              flash_cmd_reg.wdata        <= table_latch_reg;
              flash_req_reg              <= 1'b1;
              state_reg                  <= ST_FLASH;
            end
          end else if (table_take) begin
            flash_cmd_reg.op <= table_req.read ? nvac_pkg::NVAC_FL_TABLE_READ
                                               : nvac_pkg::NVAC_FL_TABLE_WRITE;
            flash_cmd_reg.config_space <= configuration_select_reg;
            flash_cmd_reg.addr         <= table_pointer_reg;
            flash_cmd_reg.wdata        <= table_latch_reg;
            post_inc_reg               <= table_req.post_inc;
            flash_req_reg              <= 1'b1;
            state_reg                  <= ST_FLASH;
          end
        end
        ST_ERASE: begin
          if (timer_reg == '0) begin
            timer_reg <= PROG_LOAD;
            state_reg <= ST_PROGRAM; // R4
          end else begin
            timer_reg <= timer_reg - TIMER_W'(1); // R5
          end
        end
        ST_PROGRAM: begin
          if (timer_reg == '0) begin
            state_reg <= ST_IDLE; // R5
          end else begin
            timer_reg <= timer_reg - TIMER_W'(1);
          end
        end
        ST_FLASH: begin
          if (flash_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered read data; unlock port and unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      sfr_rdata_reg <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        nvac_pkg::SFR_CONTROL:     sfr_rdata_reg <= control_view;
        nvac_pkg::SFR_UNLOCK:      sfr_rdata_reg <= 8'h00; // R15
        nvac_pkg::SFR_DATA:        sfr_rdata_reg <= nv_data_register_reg;
        nvac_pkg::SFR_ADDRESS:     sfr_rdata_reg <= 8'(nv_address_register_reg);
        nvac_pkg::SFR_PERIPH_TWO:  sfr_rdata_reg <= {3'h0, write_complete_flag_reg,
                                                     4'h0}; // R16
        nvac_pkg::SFR_TABLE_POINTER_LOW:  sfr_rdata_reg <= table_pointer_reg[7:0];
        nvac_pkg::SFR_TABLE_POINTER_HIGH: sfr_rdata_reg <= table_pointer_reg[15:8];
        nvac_pkg::SFR_TABLE_POINTER_UP:   sfr_rdata_reg <= {2'h0, table_pointer_reg[21:16]};
        nvac_pkg::SFR_TABLE_LATCH: sfr_rdata_reg <= table_latch_reg;
        default:                   sfr_rdata_reg <= 8'h00;
      endcase
    end
  end

endmodule

// ==== hdl/nvac_pkg.sv ====
package nvac_pkg;

  // Special function register addresses on the core's register port
  localparam logic [7:0] SFR_CONTROL     = 8'h00;
  localparam logic [7:0] SFR_UNLOCK      = 8'h01;
  localparam logic [7:0] SFR_DATA        = 8'h02;
  localparam logic [7:0] SFR_ADDRESS     = 8'h03;
  localparam logic [7:0] SFR_PERIPH_TWO  = 8'h04;
  localparam logic [7:0] SFR_TABLE_POINTER_LOW  = 8'h05;
  localparam logic [7:0] SFR_TABLE_POINTER_HIGH = 8'h06;
  localparam logic [7:0] SFR_TABLE_POINTER_UP   = 8'h07;
  localparam logic [7:0] SFR_TABLE_LATCH = 8'h08;

  // Control register field positions, and the write-done bit of flag register two
  localparam int CTL_MEMORY_SELECT = 7;
  localparam int CTL_CONFIG_SELECT = 6;
  localparam int CTL_ROW_ERASE     = 4;
  localparam int CTL_WRITE_ERROR   = 3;
  localparam int CTL_WRITE_ENABLE  = 2;
  localparam int CTL_START_WRITE   = 1;
  localparam int CTL_START_READ    = 0;
  localparam int PERIPHERAL_FLAG_REG_TWO_WRITE_DONE   = 4;

  localparam logic [7:0]  UNLOCK_KEY_FIRST  = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY_SECOND = 8'haa;
  localparam logic [7:0]  DATA_RESET        = 8'h00;
  localparam logic [21:0] TABLE_POINTER_RESET      = 22'h000000;

  // Programming timer, one phase for erase and one for program
  localparam int unsigned CLOCK_PERIOD_PS  = 5000;
  localparam int unsigned EE_ERASE_TIME_NS = 2000000;
  localparam int unsigned EE_PROG_TIME_NS  = 2000000;
  localparam int unsigned EE_ERASE_CYCLES  =
    32'((EE_ERASE_TIME_NS * 64'd1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
  localparam int unsigned EE_PROG_CYCLES   =
    32'((EE_PROG_TIME_NS * 64'd1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
  localparam int unsigned TIMER_WIDTH      = 24;

  typedef enum logic [1:0] {
    NVAC_FL_TABLE_READ,
    NVAC_FL_TABLE_WRITE,
    NVAC_FL_ROW_PROGRAM,
    NVAC_FL_ROW_ERASE
  } nvac_flash_op_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvac_sfr_req_t;

  typedef struct packed {
    logic read;
    logic write;
    logic post_inc;
  } nvac_table_req_t;

  typedef struct packed {
    nvac_flash_op_t op;
    logic           config_space;
    logic [21:0]    addr;
    logic [7:0]     wdata;
  } nvac_flash_cmd_t;

endpackage

// ==== tb/nvac_checker_assertions.sv ====
`timescale 1ns/1ps
module nvac_checker #(
  parameter int unsigned ERASE_CYCLES = 4,
  parameter int unsigned PROG_CYCLES  = 4
) (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic                      warm_reset,
  input wire nvac_pkg::nvac_sfr_req_t   sfr_req,
  input wire logic [7:0]                sfr_rdata,
  input wire nvac_pkg::nvac_table_req_t table_req,
  input wire logic                      core_stall,
  input wire logic                      flash_req,
  input wire nvac_pkg::nvac_flash_cmd_t flash_cmd,
  input wire logic                      flash_done,
  input wire logic [7:0]                flash_rdata,
  input wire logic                      write_complete_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  logic rd_ctl;
  logic wr_ctl;
  logic clr_flag;
  logic row_done;
  assign rd_ctl   = sfr_req.rd && sfr_req.addr == nvac_pkg::SFR_CONTROL;
  assign wr_ctl   = sfr_req.wr && sfr_req.addr == nvac_pkg::SFR_CONTROL;
  assign clr_flag = sfr_req.wr && sfr_req.addr == nvac_pkg::SFR_PERIPH_TWO && !sfr_req.wdata[4];
  // Done only counts while the op is still running and not aborted
  assign row_done = flash_done && flash_cmd.op[1] && core_stall && !warm_reset;

  chk_unlock_zero: assert property (sfr_req.rd && sfr_req.addr == nvac_pkg::SFR_UNLOCK
    |=> sfr_rdata == 8'h00) else $error("unlock port read not zero");
  chk_ctl_bit_five: assert property (rd_ctl |=> !sfr_rdata[5])
    else $error("control bit 5 read as one");
  chk_unmapped_zero: assert property (sfr_req.rd && sfr_req.addr > nvac_pkg::SFR_TABLE_LATCH
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  chk_req_pulse: assert property (flash_req |=> !flash_req)
    else $error("flash request longer than one cycle");
  chk_stall_on_req: assert property (flash_req |-> core_stall)
    else $error("core not stalled during flash op");
  chk_flag_on_done: assert property (row_done |=> write_complete_flag)
    else $error("write complete flag not set");
  chk_flag_soft_clear: assert property ($fell(write_complete_flag) |-> $past(clr_flag))
    else $error("write complete flag cleared by hardware");
  chk_cmd_stable: assert property (!flash_req |-> $stable(flash_cmd))
    else $error("flash command changed without request");
  chk_read_refused: assert property (wr_ctl && sfr_req.wdata[7] && sfr_req.wdata[0] ##2 rd_ctl
    |=> !sfr_rdata[0]) else $error("start read set with memory select");
  chk_error_on_write_enable: assert property (wr_ctl && sfr_req.wdata[2] && !warm_reset ##2 rd_ctl
    |=> sfr_rdata[3]) else $error("write error not set by write enable");

  cover property (flash_req && flash_cmd.op == nvac_pkg::NVAC_FL_ROW_ERASE);
  cover property ($rose(write_complete_flag));
  cover property (flash_done && flash_cmd.op == nvac_pkg::NVAC_FL_TABLE_READ);
endmodule

bind nvac_access_control nvac_checker #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES (PROG_CYCLES)
) nvac_checker_i (
  .clock(clock), .reset(reset), .warm_reset(warm_reset), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .table_req(table_req), .core_stall(core_stall),
  .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_done(flash_done),
  .flash_rdata(flash_rdata), .write_complete_flag(write_complete_flag)
);

// ==== tb/nvac_flash_model.sv ====
`timescale 1ns/1ps
module nvac_flash_model #(
  parameter int LAT = 3
) (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic                      flash_req,
  input wire nvac_pkg::nvac_flash_cmd_t flash_cmd,
  output logic                          flash_done,
  output logic [7:0]                    flash_rdata,
  output nvac_pkg::nvac_flash_cmd_t     last_cmd
);
  int cnt;
  always_ff @(posedge clock) begin
    flash_done  <= 1'b0;
    // Read bus toggles when idle so stale data never looks valid
    flash_rdata <= ~flash_rdata;
    if (reset) begin
      cnt         <= 0;
      flash_rdata <= 8'h00;
      last_cmd    <= '0;
    end else if (flash_req) begin
      last_cmd <= flash_cmd;
      cnt      <= LAT;
    end else if (cnt == 1) begin
      flash_done  <= 1'b1;
      flash_rdata <= last_cmd.addr[7:0] ^ 8'h5a;
      cnt         <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] CTL = nvac_pkg::SFR_CONTROL;
  localparam logic [7:0] UNL = nvac_pkg::SFR_UNLOCK;
  localparam logic [7:0] DAT = nvac_pkg::SFR_DATA;
  localparam logic [7:0] PR2 = nvac_pkg::SFR_PERIPH_TWO;
  logic                      clock      = 1'b0;
  logic                      reset      = 1'b1;
  logic                      warm_reset = 1'b0;
  nvac_pkg::nvac_sfr_req_t   sfr_req    = '0;
  nvac_pkg::nvac_table_req_t table_req  = '0;
  logic [7:0]                sfr_rdata;
  logic [7:0]                flash_rdata;
  logic                      core_stall;
  logic                      flash_req;
  logic                      flash_done;
  logic                      write_complete_flag;
  nvac_pkg::nvac_flash_cmd_t flash_cmd;
  nvac_pkg::nvac_flash_cmd_t last_cmd;
  int                        error_cnt   = 0;
  int                        checks_done = 0;

  always #2.5 clock = ~clock;

  // Short timer counts keep each write near ten cycles
  nvac_access_control #(.ERASE_CYCLES(4), .PROG_CYCLES(4)) nvac_access_control_i (
    .clock(clock), .reset(reset), .warm_reset(warm_reset), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .table_req(table_req), .core_stall(core_stall),
    .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_done(flash_done),
    .flash_rdata(flash_rdata), .write_complete_flag(write_complete_flag));
  nvac_flash_model nvac_flash_model_i (.clock(clock), .reset(reset), .flash_req(flash_req),
    .flash_cmd(flash_cmd), .flash_done(flash_done), .flash_rdata(flash_rdata),
    .last_cmd(last_cmd));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    error_cnt++;
    $display("mismatch at %0t wait expired got %h exp %h", $time, 8'h00, 8'h01);
    tally_and_finish();
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    sfr_req <= '0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    sfr_req <= '0;
    #1 cmp8(sfr_rdata, exp);
  endtask

  task automatic wait_idle();
    int n;
    repeat (2) @(posedge clock);
    for (n = 0; n < 60; n++) begin
      @(negedge clock);
      if (core_stall === 1'b0) break;
    end
    if (n == 60) timed_out();
    // Poll start write; avoids hard-coding the timer length
    for (n = 0; n < 30; n++) begin
      @(posedge clock);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: CTL, wdata: 8'h00};
      @(posedge clock);
      sfr_req <= '0;
      #1 if (sfr_rdata[1] === 1'b0) break;
    end
    if (n == 30) timed_out();
  endtask

  task automatic start_write(input logic [7:0] ctl);
    sfr_wr(CTL, ctl);
    sfr_wr(UNL, nvac_pkg::UNLOCK_KEY_FIRST);
    sfr_wr(UNL, nvac_pkg::UNLOCK_KEY_SECOND);
    sfr_wr(CTL, ctl | 8'h02);
  endtask

  task automatic t_reset_values();
    chk_reg(CTL, 8'h00);
    chk_reg(UNL, 8'h00);
    chk_reg(8'h3f, 8'h00);
  endtask

  task automatic t_refused();
    sfr_wr(CTL, 8'h02);
    chk_reg(CTL, 8'h00);
    sfr_wr(CTL, 8'h04);
    sfr_wr(CTL, 8'h06);
    chk_reg(CTL, 8'h0c);
    sfr_wr(UNL, nvac_pkg::UNLOCK_KEY_FIRST);
    sfr_wr(UNL, nvac_pkg::UNLOCK_KEY_SECOND);
    sfr_wr(DAT, 8'h11);
    sfr_wr(CTL, 8'h06);
    chk_reg(CTL, 8'h0c);
    sfr_wr(CTL, 8'h81);
    chk_reg(CTL, 8'h80);
    sfr_wr(CTL, 8'h00);
  endtask

  task automatic t_ee_write_read();
    logic [7:0] vals [2] = '{8'h3c, 8'hc3};
    foreach (vals[i]) begin
      sfr_wr(nvac_pkg::SFR_ADDRESS, 8'h5e);
      sfr_wr(DAT, vals[i]);
      start_write(8'h04);
      sfr_wr(CTL, 8'h04);
      chk_reg(CTL, 8'h0e);
      wait_idle();
      cmp8({7'h00, write_complete_flag}, 8'h01);
      chk_reg(CTL, 8'h04);
      chk_reg(PR2, 8'h10);
      sfr_wr(PR2, 8'h00);
      chk_reg(PR2, 8'h00);
      sfr_wr(DAT, 8'h00);
      sfr_wr(CTL, 8'h01);
      chk_reg(DAT, vals[i]);
      chk_reg(CTL, 8'h00);
    end
  endtask

  task automatic t_warm_abort();
    sfr_wr(DAT, 8'h77);
    start_write(8'h04);
    @(posedge clock);
    warm_reset <= 1'b1;
    @(posedge clock);
    warm_reset <= 1'b0;
    chk_reg(CTL, 8'h08);
    sfr_wr(CTL, 8'h00);
  endtask

  task automatic t_flash_row();
    logic [7:0]               ctl [2] = '{8'h94, 8'h44};
    nvac_pkg::nvac_flash_op_t ops [2] = '{nvac_pkg::NVAC_FL_ROW_ERASE,
                                          nvac_pkg::NVAC_FL_ROW_PROGRAM};
    sfr_wr(nvac_pkg::SFR_TABLE_POINTER_UP, 8'h01);
    sfr_wr(nvac_pkg::SFR_TABLE_POINTER_HIGH, 8'h23);
    sfr_wr(nvac_pkg::SFR_TABLE_POINTER_LOW, 8'h40);
    foreach (ctl[i]) begin
      start_write(ctl[i]);
      wait_idle();
      cmp8({6'h00, last_cmd.op}, {6'h00, ops[i]});
      cmp8({7'h00, last_cmd.config_space}, 8'(i));
      cmp8(last_cmd.addr[7:0], 8'h40);
      chk_reg(CTL, ctl[i] & 8'hef);
      chk_reg(PR2, 8'h10);
      sfr_wr(PR2, 8'h00);
    end
    sfr_wr(CTL, 8'h00);
  endtask

  // Request held until the rising edge after the falling edge at which stall is seen low
  task automatic table_op(input nvac_pkg::nvac_table_req_t r);
    int n;
    @(posedge clock);
    table_req <= r;
    for (n = 0; n < 20; n++) begin
      @(negedge clock);
      if (core_stall === 1'b0) break;
    end
    if (n == 20) timed_out();
    @(posedge clock);
    table_req <= '0;
    wait_idle();
  endtask

  task automatic t_table_read();
    sfr_wr(nvac_pkg::SFR_TABLE_POINTER_LOW, 8'h45);
    table_op('{read: 1'b1, write: 1'b0, post_inc: 1'b1});
    chk_reg(nvac_pkg::SFR_TABLE_LATCH, 8'h45 ^ 8'h5a);
    chk_reg(nvac_pkg::SFR_TABLE_POINTER_LOW, 8'h46);
    sfr_wr(nvac_pkg::SFR_TABLE_LATCH, 8'h9d);
    table_op('{read: 1'b0, write: 1'b1, post_inc: 1'b0});
    cmp8({6'h00, last_cmd.op}, {6'h00, nvac_pkg::NVAC_FL_TABLE_WRITE});
    cmp8(last_cmd.wdata, 8'h9d);
    cmp8(last_cmd.addr[7:0], 8'h46);
    chk_reg(nvac_pkg::SFR_TABLE_POINTER_LOW, 8'h46);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset_values();
    t_refused();
    t_ee_write_read();
    t_warm_abort();
    t_flash_row();
    t_table_read();
    tally_and_finish();
  end
endmodule
